/* verilog/fault_protect_pkg.sv */
package fault_protect_pkg;
  // channel count and clock rate
  localparam int NCH = 4;
  localparam int CLK_MHZ = 250;
  // register byte offsets (channel configs at CFG0 + 4*ch)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG0 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_STATE = 8'h18;
  // control register fields
  localparam int CTRL_PWM_EN = 0;
  localparam int CTRL_OVERVOLTAGE_DISABLE = 1;
  localparam int CTRL_ON_LSB = 4;
  localparam logic [31:0] CTRL_MASK = 32'h0000_00f3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // channel config fields
  localparam int CFG_HID_SEL = 0;
  localparam int CFG_SLOPE_LSB = 1;
  localparam int CFG_STEP_RM = 3;
  localparam int CFG_STEADY_LSB = 4;
  localparam int CFG_COOL_EN = 6;
  localparam int CFG_COOL_LSB = 7;
  localparam int CFG_LED = 9;
  localparam int CFG_OS_OFF = 10;
  localparam int CFG_OLOFF_OFF = 11;
  localparam int CFG_OLON_OFF = 12;
  localparam int CFG_DIR_DIS = 13;
  localparam int CFG_DUTY_LSB = 14;
  localparam logic [31:0] CFG_MASK = 32'h001f_ffff;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [6:0] DUTY_FULL = 7'h7f;
  // status register fields (4-bit per-channel groups, single ov and uv bits)
  localparam int ST_OT = 0;
  localparam int ST_OC = 4;
  localparam int ST_SC = 8;
  localparam int ST_OS = 12;
  localparam int ST_OLOFF = 16;
  localparam int ST_OLON = 20;
  localparam int ST_OV = 24;
  localparam int ST_UV = 25;
  // current limit codes driven to the analog comparator
  localparam logic [2:0] LIM_HI1 = 3'h0;
  localparam logic [2:0] LIM_HI2 = 3'h1;
  localparam logic [2:0] LIM_HI3 = 3'h2;
  localparam logic [2:0] LIM_LO1 = 3'h4;
  localparam logic [2:0] LIM_LO2 = 3'h5;
  localparam logic [2:0] LIM_LO3 = 3'h6;
  localparam logic [2:0] LIM_LO4 = 3'h7;
  localparam logic [1:0] STEP_STEADY = 2'h3;
  // retry limit and profile timing
  localparam logic [4:0] RETRY_MAX = 5'h10;
  localparam int OC_STEP_NS = 1000;
  localparam int OC_STEP_CYC = (OC_STEP_NS * CLK_MHZ) / 1000;
  localparam int HID_SHIFT = 2;
  localparam int COOL_BASE_US = 10;
  localparam int COOL_BASE_CYC = COOL_BASE_US * CLK_MHZ;
  // per-channel retry sequencer
  typedef enum logic [1:0] {
    RT_IDLE = 2'b00,
    RT_WAIT = 2'b01,
    RT_TRY = 2'b11,
    RT_DONE = 2'b10
  } retry_state_t;
endpackage : fault_protect_pkg

/* verilog/fault_protect.sv */
// Overview of operation
// - hot channel commanded on latches off and latches fault pin low
// - thermal latch frees when cool and retry, rearm toggle, or supply reset
// - hot channel commanded off holds fault pin low only while hot
// - overtemp flag set in both cases, cleared by status read
// - four-step current profile, lamp or bulb selectable, lamp default
// - slope field sets step speed; first step can be omitted
// - steady limit is second low level unless select picks another
// - overcurrent latches off, pin low, flag; released like thermal latch
// - cooling mode skips first step after short off time
// - severe short sets flag; outside steady step also latches off, pin low; retry never frees it
// - overvoltage turns all off, pin low, refuses on until cleared
// - overvoltage flag latches, read-clear when gone; disable bit turns protection off
// - undervoltage turns outputs off, sets flag, pin follows comparator
// - logic supply fail or power-on reset clears all latched faults
// - retry active in fault mode when channel oc/ot or uv flag set
// - retry every period, at most sixteen attempts per channel
// - retry counters cleared on any fail-safe mode change
// - each retry attempt uses default overcurrent settings
// - off channel shorted to battery latches two flags, pin real time
// - off open load latches flag after gate off, read-clear when gone
// - on open load sets flag only; output and pin untouched
// - led open load checked after full-on check period, read-clear
// - rearm term is direct input gated or on bit; on bit under pwm; direct input alone in fail-safe
// - fail-safe to normal clears latched faults and retry state
`timescale 1ns/1ns
module fault_protect
  import fault_protect_pkg::*;
#(
  parameter int T_AUTO_US = 10000,
  parameter int T_OLLED_US = 1000,
  parameter int T_AUTO_CYC = T_AUTO_US * CLK_MHZ,
  parameter int T_OLLED_CYC = T_OLLED_US * CLK_MHZ
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // device mode and supply events
  input wire logic fail_safe,
  input wire logic logic_supply_fail,
  input wire logic supply_por,
  // command sources
  input wire logic [3:0] direct_in,
  input wire logic [3:0] pwm_in,
  // analog comparator results
  input wire logic [3:0] ot_cmp,
  input wire logic [3:0] oc_cmp,
  input wire logic [3:0] sc_cmp,
  input wire logic [3:0] os_cmp,
  input wire logic [3:0] ol_off_cmp,
  input wire logic [3:0] ol_on_cmp,
  input wire logic [3:0] gate_low,
  input wire logic ov_cmp,
  input wire logic uv_cmp,
  // outputs to power stage and pin
  output logic [3:0] gate_on,
  output logic [11:0] oc_limit_sel,
  output logic fault_status_n
);

  localparam int AUTO_W = $clog2(T_AUTO_CYC + 1);
  localparam int OLLED_W = $clog2(T_OLLED_CYC + 1);

  // profile step length, higher slope code steps down faster
  function automatic logic [15:0] step_len(input logic [1:0] slope, input logic bulb);
    logic [2:0] sh;
    sh = 3'(2'd3 - slope) + (bulb ? 3'd0 : 3'(HID_SHIFT));
    step_len = 16'(OC_STEP_CYC) << sh;
  endfunction : step_len

  // limit code for a profile step
  function automatic logic [2:0] limit_of(input logic [1:0] step, input logic [1:0] steady);
    logic [2:0] lo;
    unique case (steady)
      2'd0: lo = LIM_LO2;
      2'd1: lo = LIM_LO1;
      2'd2: lo = LIM_LO3;
      2'd3: lo = LIM_LO4;
    endcase
    unique case (step)
      2'd0: limit_of = LIM_HI1;
      2'd1: limit_of = LIM_HI2;
      2'd2: limit_of = LIM_HI3;
      2'd3: limit_of = lo;
    endcase
  endfunction : limit_of

  logic [31:0] ctrl;
  logic [31:0] cfg [NCH];
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] rd_word;
  logic addr_phase;
  logic rd_clr;
  logic [3:0] lat_ot, lat_oc, lat_sc, lat_uv;
  logic [3:0] ot_f, oc_f, sc_f, os_f, oloff_f, olon_f;
  logic ov_f, uv_f;
  logic fail_safe_q;
  logic clr_all;
  logic [3:0] rearm, rearm_q, rearm_rise, cmd;
  logic [3:0] next_gate;
  logic [3:0] gate_q;
  logic ov_block;
  logic [3:0] os_set, oloff_set, olon_set, try_now, retry_req;
  logic fault_any;
  retry_state_t rt_state [NCH];
  logic [4:0] rt_cnt [NCH];
  logic [AUTO_W-1:0] rt_tmr [NCH];
  logic [1:0] step [NCH];
  logic [15:0] step_tmr [NCH];
  logic [3:0] def_pend, use_def;
  logic [15:0] off_tmr [NCH];
  logic [OLLED_W-1:0] led_tmr [NCH];
  logic [3:0] led_check;
  logic pwm_en;

  assign pwm_en = ctrl[CTRL_PWM_EN];
  assign addr_phase = hsel & hready & htrans[1];
  assign rd_clr = addr_phase & ~hwrite & (haddr[31:8] == 24'h0) & (haddr[7:0] == ADDR_STATUS);
  assign clr_all = logic_supply_fail | supply_por | (fail_safe ^ fail_safe_q);
  assign ov_block = ov_cmp & ~ctrl[CTRL_OVERVOLTAGE_DISABLE];

  // read mux, unmapped reads as zero
  always_comb begin
    rd_word = 32'h0;
    if (haddr[31:8] == 24'h0) begin
      if (haddr[7:0] == ADDR_CTRL) rd_word = ctrl;
      if (haddr[7:0] == ADDR_STATUS) begin
        rd_word = {6'h0, uv_f, ov_f, olon_f, oloff_f, os_f, sc_f, oc_f, ot_f};
      end
      if (haddr[7:0] == ADDR_STATE) begin
        for (int i = 0; i < NCH; i++) begin
          rd_word[i] = lat_ot[i] | lat_oc[i] | lat_sc[i] | lat_uv[i];
          rd_word[4 + i] = gate_on[i];
          rd_word[8 + i] = (rt_state[i] == RT_DONE);
        end
        rd_word[12] = fail_safe;
        rd_word[13] = ov_block;
      end
      for (int i = 0; i < NCH; i++) begin
        if (haddr[7:0] == 8'(ADDR_CFG0 + 8'(4 * i))) rd_word = cfg[i];
      end
    end
  end

  // bus handshake, zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= (addr_phase & ~hwrite) ? rd_word : 32'h0;
      wr_pend <= addr_phase & hwrite & (haddr[31:8] == 24'h0);
      if (addr_phase) wr_addr <= haddr[7:0];
    end
  end

  // configuration registers, kept while logic supply is valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
      for (int i = 0; i < NCH; i++) cfg[i] <= CFG_RESET;
    end else if (wr_pend) begin
      if (wr_addr == ADDR_CTRL) ctrl <= hwdata & CTRL_MASK;
      for (int i = 0; i < NCH; i++) begin
        if (wr_addr == 8'(ADDR_CFG0 + 8'(4 * i))) cfg[i] <= hwdata & CFG_MASK;
      end
    end
  end

  // command, rearm term and detector qualification per channel
  always_comb begin
    fault_any = ov_block | uv_cmp;
    for (int i = 0; i < NCH; i++) begin
      rearm[i] = pwm_en ? ctrl[CTRL_ON_LSB + i]
                        : (direct_in[i] & ~cfg[i][CFG_DIR_DIS]) | ctrl[CTRL_ON_LSB + i];
      cmd[i] = pwm_en ? (ctrl[CTRL_ON_LSB + i] & pwm_in[i]) : rearm[i];
      if (fail_safe) begin
        rearm[i] = direct_in[i];
        cmd[i] = direct_in[i];
      end
      rearm_rise[i] = rearm[i] & ~rearm_q[i];
      try_now[i] = (rt_state[i] == RT_TRY);
      next_gate[i] = cmd[i] & ~lat_ot[i] & ~lat_oc[i] & ~lat_sc[i] & ~lat_uv[i]
                     & ~ov_block & ~uv_cmp;
      os_set[i] = os_cmp[i] & ~gate_on[i] & gate_low[i] & ~cfg[i][CFG_OS_OFF];
      oloff_set[i] = os_set[i] | (ol_off_cmp[i] & ~gate_on[i] & gate_low[i]
                     & ~cfg[i][CFG_OLOFF_OFF]);
      olon_set[i] = ol_on_cmp[i] & ~cfg[i][CFG_OLON_OFF]
                    & (cfg[i][CFG_LED] ? led_check[i] : gate_on[i]);
      fault_any = fault_any | lat_ot[i] | lat_oc[i] | lat_sc[i]
                  | (ot_cmp[i] & ~cmd[i]) | os_set[i] | oloff_set[i];
      retry_req[i] = fault_any & (oc_f[i] | ot_f[i] | uv_f)
                     & (lat_ot[i] | lat_oc[i] | lat_uv[i]);
    end
  end

  // output stage and fault pin, on-open-load never touches them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_on <= 4'h0;
      gate_q <= 4'h0;
      rearm_q <= 4'h0;
      fail_safe_q <= 1'b0;
      fault_status_n <= 1'b1;
    end else begin
      gate_on <= next_gate;
      gate_q <= gate_on;
      rearm_q <= rearm;
      fail_safe_q <= fail_safe;
      fault_status_n <= ~fault_any;
    end
  end

  // fault latches, a new set wins over retry or rearm release, clr_all wins over a set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lat_ot <= 4'h0;
      lat_oc <= 4'h0;
      lat_sc <= 4'h0;
      lat_uv <= 4'h0;
    end else if (clr_all) begin
      lat_ot <= 4'h0;
      lat_oc <= 4'h0;
      lat_sc <= 4'h0;
      lat_uv <= 4'h0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        lat_ot[i] <= (ot_cmp[i] & cmd[i])
                     | (lat_ot[i] & ~(~ot_cmp[i] & (try_now[i] | rearm_rise[i])));
        lat_oc[i] <= (oc_cmp[i] & gate_on[i])
                     | (lat_oc[i] & ~(~oc_cmp[i] & (try_now[i] | rearm_rise[i])));
        lat_sc[i] <= (sc_cmp[i] & gate_on[i] & (step[i] != STEP_STEADY))
                     | (lat_sc[i] & ~(~sc_cmp[i] & rearm_rise[i]));
        lat_uv[i] <= uv_cmp
                     | (lat_uv[i] & ~(try_now[i] | rearm_rise[i]));
      end
    end
  end

  // status flags, clear on read unless the event is present
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ot_f <= 4'h0;
      oc_f <= 4'h0;
      sc_f <= 4'h0;
      os_f <= 4'h0;
      oloff_f <= 4'h0;
      olon_f <= 4'h0;
      ov_f <= 1'b0;
      uv_f <= 1'b0;
    end else if (clr_all) begin
      ot_f <= 4'h0;
      oc_f <= 4'h0;
      sc_f <= 4'h0;
      os_f <= 4'h0;
      oloff_f <= 4'h0;
      olon_f <= 4'h0;
      ov_f <= 1'b0;
      uv_f <= 1'b0;
    end else begin
      ot_f <= ot_cmp | (ot_f & {4{~rd_clr}});
      oc_f <= (oc_cmp & gate_on) | (oc_f & {4{~rd_clr}});
      sc_f <= (sc_cmp & gate_on) | (sc_f & {4{~rd_clr}});
      os_f <= os_set | (os_f & {4{~rd_clr}});
      oloff_f <= oloff_set | (oloff_f & {4{~rd_clr}});
      olon_f <= olon_set | (olon_f & {4{~rd_clr}});
      ov_f <= ov_cmp | (ov_f & ~rd_clr);
      uv_f <= uv_cmp | (uv_f & ~rd_clr);
    end
  end

  // auto-retry sequencer per channel
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NCH; i++) begin
        rt_state[i] <= RT_IDLE;
        rt_cnt[i] <= 5'h0;
        rt_tmr[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (clr_all) begin
          rt_state[i] <= RT_IDLE;
          rt_cnt[i] <= 5'h0;
          rt_tmr[i] <= '0;
        end else begin
          unique case (rt_state[i])
            RT_IDLE: begin
              rt_tmr[i] <= '0;
              if (retry_req[i] && rt_cnt[i] < RETRY_MAX) rt_state[i] <= RT_WAIT;
            end
            RT_WAIT: begin
              if (!(lat_ot[i] | lat_oc[i] | lat_uv[i])) begin
                rt_state[i] <= RT_IDLE;
              end else if (rt_tmr[i] == AUTO_W'(T_AUTO_CYC - 1)) begin
                rt_state[i] <= RT_TRY;
                rt_cnt[i] <= rt_cnt[i] + 5'h1;
              end else begin
                rt_tmr[i] <= rt_tmr[i] + 1'b1;
              end
            end
            RT_TRY: rt_state[i] <= (rt_cnt[i] == RETRY_MAX) ? RT_DONE : RT_IDLE;
            RT_DONE: rt_state[i] <= RT_DONE;
          endcase
        end
      end
    end
  end

  // overcurrent profile stepping and limit select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      def_pend <= 4'h0;
      use_def <= 4'h0;
      oc_limit_sel <= 12'h0;
      for (int i = 0; i < NCH; i++) begin
        step[i] <= 2'h0;
        step_tmr[i] <= 16'h0;
        off_tmr[i] <= 16'h0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (try_now[i]) def_pend[i] <= 1'b1;
        off_tmr[i] <= gate_on[i] ? 16'h0 : (&off_tmr[i] ? off_tmr[i] : off_tmr[i] + 16'h1);
        if (gate_on[i] && !gate_q[i]) begin
          use_def[i] <= def_pend[i] | try_now[i];
          def_pend[i] <= 1'b0;
          step_tmr[i] <= 16'h0;
          if (def_pend[i]) begin
            step[i] <= 2'h0;
          end else if (cfg[i][CFG_STEP_RM]) begin
            step[i] <= 2'h1;
          end else if (pwm_en && !fail_safe && cfg[i][CFG_COOL_EN] && cfg[i][CFG_HID_SEL]
                       && off_tmr[i] < (16'(COOL_BASE_CYC) << cfg[i][CFG_COOL_LSB +: 2])) begin
            step[i] <= 2'h1;
          end else begin
            step[i] <= 2'h0;
          end
        end else if (step[i] != STEP_STEADY) begin
          if (step_tmr[i] >= step_len(use_def[i] ? 2'h0 : cfg[i][CFG_SLOPE_LSB +: 2],
                                      ~use_def[i] & cfg[i][CFG_HID_SEL]) - 16'h1) begin
            step[i] <= step[i] + 2'h1;
            step_tmr[i] <= 16'h0;
          end else begin
            step_tmr[i] <= step_tmr[i] + 16'h1;
          end
        end
        oc_limit_sel[3 * i +: 3] <= limit_of(step[i],
                                    use_def[i] ? 2'h0 : cfg[i][CFG_STEADY_LSB +: 2]);
      end
    end
  end

  // periodic led open-load check while fully on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_check <= 4'h0;
      for (int i = 0; i < NCH; i++) led_tmr[i] <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        led_check[i] <= 1'b0;
        if (!(gate_on[i] && cfg[i][CFG_LED]
              && (!pwm_en || cfg[i][CFG_DUTY_LSB +: 7] == DUTY_FULL))) begin
          led_tmr[i] <= '0;
        end else if (led_tmr[i] == OLLED_W'(T_OLLED_CYC - 1)) begin
          led_tmr[i] <= '0;
          led_check[i] <= 1'b1;
        end else begin
          led_tmr[i] <= led_tmr[i] + 1'b1;
        end
      end
    end
  end

endmodule : fault_protect

/* verification/fault_protect_checker.sv */
`timescale 1ns/1ns
module fault_protect_checker (
  // bus side
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // supply events and comparators
  input wire logic logic_supply_fail,
  input wire logic supply_por,
  input wire logic [3:0] ot_cmp,
  input wire logic [3:0] oc_cmp,
  input wire logic [3:0] sc_cmp,
  input wire logic [3:0] os_cmp,
  input wire logic [3:0] ol_off_cmp,
  input wire logic [3:0] gate_low,
  input wire logic ov_cmp,
  input wire logic uv_cmp,
  // power stage and pin
  input wire logic [3:0] gate_on,
  input wire logic [11:0] oc_limit_sel,
  input wire logic fault_status_n
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // no comparator other than on open load reports any fault
  logic quiet;
  assign quiet = (ot_cmp | oc_cmp | sc_cmp | os_cmp | ol_off_cmp) == 4'h0 && !ov_cmp && !uv_cmp;
  // channel 0 dropped with pin low
  sequence s_trip;
    ##[1:2] (!gate_on[0] && !fault_status_n);
  endsequence
  sequence s_idle;
    !(hsel && hready && htrans[1]);
  endsequence
  property p_ot_on;
    ot_cmp[0] && gate_on[0] |-> s_trip;
  endproperty
  property p_ot_off;
    ot_cmp[0] && !gate_on[0] |-> ##[1:2] !fault_status_n;
  endproperty
  property p_oc;
    oc_cmp[0] && gate_on[0] |-> s_trip;
  endproperty
  property p_sc;
    sc_cmp[0] && gate_on[0] && !oc_limit_sel[2] |-> ##[1:2] !gate_on[0];
  endproperty
  property p_uv;
    uv_cmp |-> ##[1:2] (gate_on == 4'h0 && !fault_status_n);
  endproperty
  property p_supply;
    ((supply_por || logic_supply_fail) && quiet) [*2] |=> fault_status_n;
  endproperty
  property p_os;
    os_cmp[0] && gate_low[0] && !gate_on[0] |-> ##[1:2] !fault_status_n;
  endproperty
  property p_rdata;
    s_idle |=> hrdata == 32'h0;
  endproperty
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_ot_on: assert property (p_ot_on) else $error("hot channel not latched off");
  a_ot_off: assert property (p_ot_off) else $error("hot idle channel pin high");
  a_oc: assert property (p_oc) else $error("overcurrent not latched off");
  a_sc: assert property (p_sc) else $error("severe short not latched off");
  a_uv: assert property (p_uv) else $error("undervoltage left outputs on");
  a_supply: assert property (p_supply) else $error("supply reset left pin low");
  a_os: assert property (p_os) else $error("battery short not on pin");
  a_rdata: assert property (p_rdata) else $error("read data outside data phase");
  a_okay: assert property (p_okay) else $error("response not okay");
endmodule : fault_protect_checker

bind fault_protect fault_protect_checker u_fault_protect_checker (
  .hclk, .hresetn, .hsel, .htrans, .hready, .hresp, .hrdata, .logic_supply_fail, .supply_por,
  .ot_cmp, .oc_cmp, .sc_cmp, .os_cmp, .ol_off_cmp, .gate_low, .ov_cmp, .uv_cmp, .gate_on,
  .oc_limit_sel, .fault_status_n
);

/* verification/power_stage_model.sv */
`timescale 1ns/1ns
module power_stage_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // gate drive in, discharge state out
  input wire logic [3:0] gate_on,
  output logic [3:0] gate_low
);
  // gate discharges one cycle after drive drops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_low <= 4'hf;
    end else begin
      gate_low <= ~gate_on;
    end
  end
endmodule : power_stage_model

/* verification/test_switch_fault_protection_logic.sv */
`timescale 1ns/1ns
module test_switch_fault_protection_logic;
  import fault_protect_pkg::*;
  // driven and observed signals
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fail_safe = 1'b0;
  logic logic_supply_fail = 1'b0, supply_por = 1'b0, ov_cmp = 1'b0, uv_cmp = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [3:0] direct_in = 4'h0, ot_cmp = 4'h0, oc_cmp = 4'h0, sc_cmp = 4'h0, pwm_in = 4'h0;
  logic [3:0] os_cmp = 4'h0, ol_off_cmp = 4'h0, ol_on_cmp = 4'h0, gate_on, gate_low;
  logic hready, hreadyout, hresp, fault_status_n;
  logic [11:0] oc_limit_sel;
  int errors = 0;
  int n_compared = 0;
  assign hready = hreadyout;
  // clock
  always #2 hclk = ~hclk;
  fault_protect #(.T_AUTO_CYC(20), .T_OLLED_CYC(16)) u_fault_protect (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .fail_safe(fail_safe), .supply_por(supply_por),
    .logic_supply_fail(logic_supply_fail), .direct_in(direct_in), .pwm_in(pwm_in),
    .ot_cmp(ot_cmp), .oc_cmp(oc_cmp), .sc_cmp(sc_cmp), .os_cmp(os_cmp),
    .ol_off_cmp(ol_off_cmp), .ol_on_cmp(ol_on_cmp), .gate_low(gate_low), .ov_cmp(ov_cmp),
    .uv_cmp(uv_cmp), .gate_on(gate_on), .oc_limit_sel(oc_limit_sel),
    .fault_status_n(fault_status_n)
  );
  power_stage_model u_power_stage_model (
    .hclk(hclk), .hresetn(hresetn), .gate_on(gate_on), .gate_low(gate_low)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick
  // one single transfer, waits on ready in both phases
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask : rd
  // quiet comparators, then a logic supply drop wipes faults
  task automatic clean();
    {ot_cmp, oc_cmp, sc_cmp, os_cmp, ol_off_cmp, ol_on_cmp, direct_in} <= 28'h0;
    {ov_cmp, uv_cmp, logic_supply_fail} <= 3'h1;
    tick(2);
    logic_supply_fail <= 1'b0;
    tick(3);
  endtask : clean
  // overloaded channel 0: current comparator trips only while driven
  task automatic count_rises(output int n);
    logic prev;
    prev = 1'b0;
    n = 0;
    repeat (1200) begin
      @(posedge hclk);
      oc_cmp <= {3'h0, gate_on[0]};
      if (gate_on[0] === 1'b1 && prev !== 1'b1) n++;
      prev = gate_on[0];
    end
  endtask : count_rises
  task automatic t_regs();
    rd(ADDR_CTRL, CTRL_RESET);
    rd(ADDR_CFG0 + 8'hc, CFG_RESET);
    wr(ADDR_CFG0 + 8'hc, 32'hffff_ffff);
    rd(ADDR_CFG0 + 8'hc, CFG_MASK);
    wr(ADDR_CFG0 + 8'hc, CFG_RESET);
    wr(ADDR_STATUS, 32'hffff_ffff);
    rd(ADDR_STATUS, 32'h0);
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0);
  endtask : t_regs
  task automatic t_ot_on();
    clean();
    direct_in <= 4'h1;
    tick(4);
    check(32'(gate_on), 32'h1);
    ot_cmp <= 4'h1;
    tick(3);
    ot_cmp <= 4'h0;
    check(32'({gate_on, fault_status_n}), 32'h0);
    tick(3);
    check(32'(fault_status_n), 32'h0);
    rd(ADDR_STATUS, 32'h1);
    rd(ADDR_STATUS, 32'h0);
    direct_in <= 4'h0;
    tick(3);
    direct_in <= 4'h1;
    tick(4);
    check(32'({gate_on, fault_status_n}), 32'h3);
  endtask : t_ot_on
  task automatic t_ot_off();
    clean();
    ot_cmp <= 4'h1;
    tick(3);
    check(32'(fault_status_n), 32'h0);
    ot_cmp <= 4'h0;
    tick(3);
    check(32'({gate_on, fault_status_n}), 32'h1);
    rd(ADDR_STATUS, 32'h1);
  endtask : t_ot_off
  task automatic t_oc();
    int n;
    clean();
    direct_in <= 4'h1;
    count_rises(n);
    check(32'(n), 32'd17);
    check(32'(fault_status_n), 32'h0);
    rd(ADDR_STATUS, 32'h10);
    fail_safe <= 1'b1;
    count_rises(n);
    check(32'(n), 32'd17);
    fail_safe <= 1'b0;
    tick(3);
    check(32'({gate_on, fault_status_n}), 32'h3);
  endtask : t_oc
  task automatic t_sc();
    clean();
    direct_in <= 4'h1;
    tick(3);
    sc_cmp <= 4'h1;
    tick(3);
    sc_cmp <= 4'h0;
    check(32'({gate_on, fault_status_n}), 32'h0);
    tick(60);
    check(32'(gate_on), 32'h0);
    rd(ADDR_STATUS, 32'h100);
    direct_in <= 4'h0;
    tick(3);
    direct_in <= 4'h1;
    tick(4);
    check(32'(gate_on), 32'h1);
  endtask : t_sc
  task automatic t_ov();
    clean();
    direct_in <= 4'hf;
    tick(4);
    ov_cmp <= 1'b1;
    tick(3);
    check(32'({gate_on, fault_status_n}), 32'h0);
    rd(ADDR_STATUS, 32'h0100_0000);
    rd(ADDR_STATUS, 32'h0100_0000);
    ov_cmp <= 1'b0;
    tick(3);
    check(32'(gate_on), 32'hf);
    rd(ADDR_STATUS, 32'h0100_0000);
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_CTRL, 32'h1 << CTRL_OVERVOLTAGE_DISABLE);
    ov_cmp <= 1'b1;
    tick(3);
    check(32'(gate_on), 32'hf);
    wr(ADDR_CTRL, CTRL_RESET);
  endtask : t_ov
  task automatic t_uv();
    clean();
    direct_in <= 4'h1;
    tick(4);
    uv_cmp <= 1'b1;
    tick(3);
    check(32'({gate_on, fault_status_n}), 32'h0);
    uv_cmp <= 1'b0;
    tick(3);
    check(32'(fault_status_n), 32'h1);
    tick(40);
    check(32'(gate_on), 32'h1);
    rd(ADDR_STATUS, 32'h0200_0000);
  endtask : t_uv
  task automatic t_off_diag();
    clean();
    os_cmp <= 4'h1;
    tick(3);
    check(32'(fault_status_n), 32'h0);
    os_cmp <= 4'h0;
    tick(3);
    check(32'(fault_status_n), 32'h1);
    rd(ADDR_STATUS, 32'h0001_1000);
    ol_off_cmp <= 4'h2;
    tick(3);
    ol_off_cmp <= 4'h0;
    tick(3);
    rd(ADDR_STATUS, 32'h0002_0000);
    rd(ADDR_STATUS, 32'h0);
  endtask : t_off_diag
  task automatic t_on_open();
    clean();
    direct_in <= 4'h1;
    tick(4);
    ol_on_cmp <= 4'h1;
    tick(4);
    check(32'({gate_on, fault_status_n}), 32'h3);
    ol_on_cmp <= 4'h0;
    rd(ADDR_STATUS, 32'h0010_0000);
    // led load: flag only after a full check period on
    wr(ADDR_CFG0, 32'h200);
    ol_on_cmp <= 4'h1;
    tick(4);
    rd(ADDR_STATUS, 32'h0);
    tick(20);
    rd(ADDR_STATUS, 32'h0010_0000);
  endtask : t_on_open
  // bulb, fastest slope, first step gone, steady low level 1
  task automatic t_limits();
    wr(ADDR_CFG0, 32'h1f);
    clean();
    direct_in <= 4'h1;
    tick(4);
    check(32'(oc_limit_sel[2:0]), 32'(LIM_HI2));
    tick(1000);
    check(32'(oc_limit_sel[2:0]), 32'(LIM_LO1));
    wr(ADDR_CFG0, CFG_RESET);
    direct_in <= 4'h0;
    tick(3);
    direct_in <= 4'h1;
    tick(4);
    check(32'(oc_limit_sel[2:0]), 32'(LIM_HI1));
    // pwm drive after a short off time: cooling skips the first step
    wr(ADDR_CFG0, 32'h41);
    wr(ADDR_CTRL, 32'h11);
    tick(2);
    pwm_in <= 4'h1;
    tick(4);
    check(32'(gate_on), 32'h1);
    check(32'(oc_limit_sel[2:0]), 32'(LIM_HI2));
    wr(ADDR_CTRL, CTRL_RESET);
  endtask : t_limits
  task automatic t_supply();
    clean();
    direct_in <= 4'h2;
    tick(3);
    ot_cmp <= 4'h2;
    tick(3);
    ot_cmp <= 4'h0;
    supply_por <= 1'b1;
    tick(2);
    supply_por <= 1'b0;
    tick(3);
    check(32'({gate_on, fault_status_n}), 32'h5);
  endtask : t_supply
  task automatic final_report();
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // main sequence
  initial begin
    tick(6);
    hresetn <= 1'b1;
    tick(1);
    t_regs();
    t_ot_on();
    t_ot_off();
    t_oc();
    t_sc();
    t_ov();
    t_uv();
    t_off_diag();
    t_on_open();
    t_limits();
    t_supply();
    final_report();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    final_report();
  end
endmodule : test_switch_fault_protection_logic
